// ==== hdl/boot_image_loader.v ====
// Boot source selection and image loader for one processor tile
`timescale 1ns/1ps
`include "boot_loader_consts.vh"
module boot_image_loader #(
  parameter HALF_DIV   = `BOOT_HALF_DIV,
  parameter RAM_AW     = 19,
  parameter OTP_AW     = 12,
  parameter FIFO_DEPTH = 32,
  parameter FIFO_AW    = 5
) (
  input  wire              core_clk,
  input  wire              srst,
  input  wire [31:0]       security_word,
  input  wire [3:0]        quad_data_in,
  output reg  [3:0]        quad_data_out,
  output reg  [3:0]        quad_data_oe,
  output reg               strap_pulldown_en,
  output reg               flash_select_pin_out,
  output reg               flash_select_pin_oe,
  input  wire              serial_clock_pin_in,
  output reg               serial_clock_pin_out,
  output reg               serial_clock_pin_oe,
  input  wire              serial_out_or_in_pin_in,
  output reg               serial_out_or_in_pin_out,
  output reg               serial_out_or_in_pin_oe,
  input  wire              serial_in_or_select_pin_in,
  input  wire              link_clk,
  input  wire [8:0]        link_rx_data,
  output reg  [3:0]        link_tx_low_en,
  output reg  [3:0]        link_pulldown_en,
  output reg               link_end_send,
  output reg  [31:0]       link_end_dest,
  output reg               chan_end0_busy,
  output reg               otp_rd_req,
  output reg  [OTP_AW-1:0] otp_rd_addr,
  input  wire [7:0]        otp_rd_data,
  input  wire              otp_rd_valid,
  output reg               ram_we,
  output reg  [RAM_AW-1:0] ram_addr,
  output reg  [7:0]        ram_wdata,
  output reg               boot_exec,
  output reg  [RAM_AW-1:0] exec_addr,
  output reg               boot_fail,
  output reg               crc_error,
  output reg               rx_overflow
);

  // =====================================================
  // Modes and parser states
  localparam MD_NONE = 6'b000000;
  localparam MD_QUAD = 6'b000001;
  localparam MD_SPI  = 6'b000010;
  localparam MD_SLV  = 6'b000100;
  localparam MD_LINK = 6'b001000;
  localparam MD_OTP  = 6'b010000;
  localparam MD_BAD  = 6'b100000;

  // Sized copies of shared constants, so bit picks and slices stay explicit
  localparam [7:0]  CMD_QUAD = `BOOT_CMD_QUAD;
  localparam [7:0]  CMD_READ = `BOOT_CMD_READ;
  localparam [31:0] RAM_BASE = `BOOT_RAM_BASE;
  localparam [31:0] OTP_BASE = `BOOT_OTP_BASE;

  localparam P_IDLE = 9'b000000001;
  localparam P_DEST = 9'b000000010;
  localparam P_LEN  = 9'b000000100;
  localparam P_PROG = 9'b000001000;
  localparam P_CRC  = 9'b000010000;
  localparam P_EOT  = 9'b000100000;
  localparam P_ACK  = 9'b001000000;
  localparam P_DONE = 9'b010000000;
  localparam P_FAIL = 9'b100000000;

  // Decode the tile's boot source
  function [5:0] pick_mode;
    input [2:0] code;
    input       secure;
    begin
      if (secure) begin
        pick_mode = MD_OTP;
      end else begin
        case (code)
          `BOOT_STRAP_QUAD:   pick_mode = MD_QUAD;
          `BOOT_STRAP_SPI:    pick_mode = MD_SPI;
          `BOOT_STRAP_SLV:    pick_mode = MD_SLV;
          `BOOT_STRAP_SLVALL: pick_mode = MD_SLV;
          `BOOT_STRAP_LINK2:  pick_mode = MD_LINK;
          `BOOT_STRAP_LINK5:  pick_mode = MD_LINK;
          default:            pick_mode = MD_BAD;
        endcase
      end
    end
  endfunction

  // Shift one bit in at the top, low bit first
  function [7:0] lsb_shift;
    input [7:0] sh;
    input       b;
    begin
      lsb_shift = {b, sh[7:1]};
    end
  endfunction

  // =====================================================
  // Pin synchronisers
  reg  [7:0] pin_s1_q;
  reg  [7:0] pin_s2_q;
  reg  [8:0] lnk_s1_q;
  reg  [8:0] lnk_s2_q;
  reg        lclk_prev_q;
  reg        sclk_prev_q;
  wire [3:0] q_s    = pin_s2_q[3:0];
  wire       sck_s  = pin_s2_q[4];
  wire       mosi_s = pin_s2_q[5];
  wire       misc_s = pin_s2_q[6];
  wire       lclk_s = pin_s2_q[7];

  // Two flops on every pin input
  always @(posedge core_clk) begin
    pin_s1_q <= {link_clk, serial_in_or_select_pin_in, serial_out_or_in_pin_in,
                 serial_clock_pin_in, quad_data_in};
    pin_s2_q <= pin_s1_q;
    lnk_s1_q <= link_rx_data;
    lnk_s2_q <= lnk_s1_q;
  end

  // =====================================================
  // Source side state
  reg  [5:0]         mode_q;
  reg                run_q;
  reg  [7:0]         strap_cnt_q;
  reg  [2:0]         strap_q;
  reg                in_v_q;
  reg  [8:0]         in_d_q;
  reg                mst_q;
  reg  [7:0]         cmd_q;
  reg  [7:0]         div_q;
  reg                sclk_q;
  reg  [5:0]         clk_n_q;
  reg  [7:0]         rx_sh_q;
  reg  [2:0]         rb_q;
  reg                otp_pend_q;
  reg  [8:0]         p_q;
  wire               fifo_in_ready;
  wire               fifo_out_valid;
  wire [8:0]         fifo_out_data;
  wire               is_quad   = (mode_q == MD_QUAD);
  wire [5:0]         data_clk  = is_quad ? `BOOT_QDATA_CLK : `BOOT_SDATA_CLK;
  wire               in_data   = (clk_n_q == data_clk);
  wire               finished  = (p_q == P_DONE) || (p_q == P_FAIL);
  wire [5:0]         clk_n1    = clk_n_q + 6'h01;
  wire [7:0]         ser_byte  = lsb_shift(rx_sh_q, misc_s);
  wire [7:0]         slv_byte  = lsb_shift(rx_sh_q, mosi_s);

  // Strap capture, pin set-up and all byte producers
  always @(posedge core_clk) begin
    if (srst) begin
      mode_q <= MD_NONE;  run_q <= 1'b0;  strap_cnt_q <= 8'h00;  strap_q <= 3'h0;
      strap_pulldown_en <= 1'b1;
      in_v_q <= 1'b0;  in_d_q <= 9'h000;  mst_q <= 1'b0;  cmd_q <= 8'h00;
      div_q <= 8'h00;  sclk_q <= 1'b0;  clk_n_q <= 6'h00;  rx_sh_q <= 8'h00;
      rb_q <= 3'h0;  otp_pend_q <= 1'b0;
      quad_data_out <= 4'h0;  quad_data_oe <= 4'h0;
      flash_select_pin_out <= 1'b1;  flash_select_pin_oe <= 1'b0;
      serial_clock_pin_out <= 1'b0;  serial_clock_pin_oe <= 1'b0;
      serial_out_or_in_pin_out <= 1'b0;  serial_out_or_in_pin_oe <= 1'b0;
      link_tx_low_en <= 4'h0;  link_pulldown_en <= 4'hF;
      otp_rd_req <= 1'b0;  otp_rd_addr <= OTP_BASE[OTP_AW-1:0];  rx_overflow <= 1'b0;
      lclk_prev_q <= 1'b0;  sclk_prev_q <= 1'b0;
    end else begin
      in_v_q      <= 1'b0;
      otp_rd_req  <= 1'b0;
      lclk_prev_q <= lclk_s;
      sclk_prev_q <= sck_s;
      if (in_v_q && !fifo_in_ready) begin
        rx_overflow <= 1'b1;
      end
      if (!run_q) begin
        if (strap_cnt_q != `BOOT_STRAP_CYC - 1) begin
          strap_cnt_q <= strap_cnt_q + 8'h01;
        end else begin
          run_q             <= 1'b1;
          strap_pulldown_en <= 1'b0;
          strap_q           <= q_s[2:0];
          mode_q <= pick_mode(q_s[2:0], security_word[`BOOT_SECURE_BIT]);
          case (pick_mode(q_s[2:0], security_word[`BOOT_SECURE_BIT]))
            MD_QUAD: begin
              mst_q <= 1'b1;  cmd_q <= `BOOT_CMD_QUAD;
              flash_select_pin_out <= 1'b0;  flash_select_pin_oe <= 1'b1;
              serial_clock_pin_oe <= 1'b1;
              quad_data_oe  <= 4'h1;
              quad_data_out <= {3'h0, CMD_QUAD[7]};
            end
            MD_SPI: begin
              mst_q <= 1'b1;  cmd_q <= `BOOT_CMD_READ;
              flash_select_pin_out <= 1'b0;  flash_select_pin_oe <= 1'b1;
              serial_clock_pin_oe <= 1'b1;
              serial_out_or_in_pin_oe  <= 1'b1;
              serial_out_or_in_pin_out <= CMD_READ[7];
            end
            MD_LINK: begin
              link_tx_low_en   <= (q_s[2:0] == `BOOT_STRAP_LINK5) ? `BOOT_LINKS_5W
                                                                  : `BOOT_LINKS_2W;
              link_pulldown_en <= (q_s[2:0] == `BOOT_STRAP_LINK5) ? ~`BOOT_LINKS_5W
                                                                  : ~`BOOT_LINKS_2W;
            end
            default: begin
              mst_q <= 1'b0;
            end
          endcase
        end
      end else if (mst_q) begin
        // Master flash engine, mode 0/0
        if (finished) begin
          mst_q <= 1'b0;  sclk_q <= 1'b0;  serial_clock_pin_out <= 1'b0;
          flash_select_pin_out <= 1'b1;  quad_data_oe <= 4'h0;
        end else if (div_q != HALF_DIV - 1) begin
          div_q <= div_q + 8'h01;
        end else if (!sclk_q) begin
          // Rising edge; stalls while the FIFO has no room
          if (!(in_data && (in_v_q || !fifo_in_ready))) begin
            div_q <= 8'h00;  sclk_q <= 1'b1;  serial_clock_pin_out <= 1'b1;
            if (in_data && is_quad) begin
              if (!rb_q[0]) begin
                rx_sh_q[3:0] <= q_s;  rb_q <= 3'h1;
              end else begin
                in_v_q <= 1'b1;  in_d_q <= {1'b0, q_s, rx_sh_q[3:0]};  rb_q <= 3'h0;
              end
            end else if (in_data) begin
              rx_sh_q <= ser_byte;  rb_q <= rb_q + 3'h1;
              if (rb_q == 3'h7) begin
                in_v_q <= 1'b1;  in_d_q <= {1'b0, ser_byte};
              end
            end
          end
        end else begin
          // Falling edge: present the next command or address bit
          div_q <= 8'h00;  sclk_q <= 1'b0;  serial_clock_pin_out <= 1'b0;
          cmd_q <= {cmd_q[6:0], 1'b0};
          if (!in_data) begin
            clk_n_q <= clk_n1;
          end
          if (is_quad) begin
            if (clk_n1 < `BOOT_CMD_CLKS) begin
              quad_data_out <= {3'h0, cmd_q[6]};  quad_data_oe <= 4'h1;
            end else if (clk_n1 < `BOOT_QADDR_END) begin
              quad_data_out <= 4'h0;  quad_data_oe <= 4'hF;
            end else begin
              quad_data_oe <= 4'h0;
            end
          end else begin
            serial_out_or_in_pin_out <= cmd_q[6];
          end
        end
      end else if (mode_q == MD_SLV && !finished) begin
        if (misc_s) begin
          rb_q <= 3'h0;
        end else if (sck_s && !sclk_prev_q) begin
          rx_sh_q <= slv_byte;  rb_q <= rb_q + 3'h1;
          if (rb_q == 3'h7) begin
            in_v_q <= 1'b1;  in_d_q <= {1'b0, slv_byte};
          end
        end
      end else if (mode_q == MD_LINK && !finished) begin
        // Link symbol taken on each link clock rise
        if (lclk_s && !lclk_prev_q) begin
          in_v_q <= 1'b1;  in_d_q <= lnk_s2_q;
        end
      end else if (mode_q == MD_OTP && !finished) begin
        if (otp_pend_q) begin
          if (otp_rd_valid) begin
            otp_pend_q <= 1'b0;  in_v_q <= 1'b1;  in_d_q <= {1'b0, otp_rd_data};
            otp_rd_addr <= otp_rd_addr + 1'b1;
          end
        end else if (fifo_in_ready && !in_v_q) begin
          otp_rd_req <= 1'b1;  otp_pend_q <= 1'b1;
        end
      end
    end
  end

  // =====================================================
  // Buffer and CRC
  wire        take;
  wire [31:0] crc_next;
  reg  [31:0] crc_q;
  wire        p_eat = (p_q == P_DEST) || (p_q == P_LEN) || (p_q == P_PROG) ||
                      (p_q == P_CRC) || (p_q == P_EOT);

  boot_byte_fifo #(.W(9), .DEPTH(FIFO_DEPTH), .AW(FIFO_AW)) u_fifo (
    .clk       (core_clk),
    .srst      (srst),
    .in_valid  (in_v_q),
    .in_ready  (fifo_in_ready),
    .in_data   (in_d_q),
    .out_valid (fifo_out_valid),
    .out_ready (p_eat),
    .out_data  (fifo_out_data)
  );

  boot_crc32_step u_crc (
    .crc_in  (crc_q),
    .data    (fifo_out_data[7:0]),
    .crc_out (crc_next)
  );

  // =====================================================
  // Image parser
  reg  [31:0]       w_q;
  reg  [1:0]        bi_q;
  reg  [33:0]       rem_q;
  reg  [31:0]       dest_q;
  reg  [RAM_AW-1:0] wr_addr_q;
  wire [31:0]       nw = {fifo_out_data[7:0], w_q[31:8]};
  assign take = fifo_out_valid && p_eat;

  // Parse count, program, CRC and link tokens
  always @(posedge core_clk) begin
    if (srst) begin
      p_q <= P_IDLE;  crc_q <= `BOOT_CRC_INIT;  w_q <= 32'h00000000;  bi_q <= 2'h0;
      rem_q <= 34'h000000000;  dest_q <= `BOOT_NULL_CHAN;
      wr_addr_q <= RAM_BASE[RAM_AW-1:0];  ram_we <= 1'b0;  ram_addr <= RAM_BASE[RAM_AW-1:0];
      ram_wdata <= 8'h00;  boot_exec <= 1'b0;  exec_addr <= RAM_BASE[RAM_AW-1:0];
      boot_fail <= 1'b0;  crc_error <= 1'b0;  chan_end0_busy <= 1'b0;
      link_end_send <= 1'b0;  link_end_dest <= `BOOT_NULL_CHAN;
    end else begin
      ram_we        <= 1'b0;
      link_end_send <= 1'b0;
      if (take) begin
        w_q  <= nw;
        bi_q <= bi_q + 2'h1;
      end
      case (p_q)
        P_IDLE: begin
          crc_q <= `BOOT_CRC_INIT;
          if (mode_q == MD_BAD) begin
            p_q <= P_FAIL;
          end else if (mode_q == MD_LINK) begin
            chan_end0_busy <= 1'b1;  p_q <= P_DEST;
          end else if (mode_q != MD_NONE) begin
            p_q <= P_LEN;
          end
        end
        P_DEST: begin
          if (take && bi_q == 2'h3) begin
            dest_q <= nw;  p_q <= P_LEN;
          end
        end
        P_LEN: begin
          if (take) begin
            crc_q <= crc_next;
            if (bi_q == 2'h3) begin
              rem_q <= {nw, 2'b00};
              p_q   <= (nw == 32'h00000000) ? P_CRC : P_PROG;
            end
          end
        end
        P_PROG: begin
          if (take) begin
            crc_q <= crc_next;  ram_we <= 1'b1;  ram_addr <= wr_addr_q;
            ram_wdata <= fifo_out_data[7:0];  wr_addr_q <= wr_addr_q + 1'b1;
            rem_q <= rem_q - 34'h000000001;
            if (rem_q == 34'h000000001) begin
              p_q <= P_CRC;
            end
          end
        end
        P_CRC: begin
          if (take && bi_q == 2'h3) begin
            if (nw == `BOOT_SKIP_MARKER || nw == ~crc_q) begin
              p_q <= (mode_q == MD_LINK) ? P_EOT : P_DONE;
            end else begin
              crc_error <= 1'b1;  boot_fail <= 1'b1;  p_q <= P_FAIL;
            end
          end
        end
        P_EOT: begin
          if (take && fifo_out_data[8] && fifo_out_data[7:0] == `BOOT_END_TOKEN) begin
            p_q <= P_ACK;
          end
        end
        P_ACK: begin
          link_end_send  <= (dest_q != `BOOT_NULL_CHAN);
          link_end_dest  <= dest_q;
          chan_end0_busy <= 1'b0;
          p_q            <= P_DONE;
        end
        P_DONE: begin
          boot_exec <= 1'b1;  exec_addr <= RAM_BASE[RAM_AW-1:0];
        end
        P_FAIL: begin
          boot_fail <= 1'b1;
        end
        default: begin
          p_q <= P_FAIL;
        end
      endcase
    end
  end

endmodule

// ==== hdl/boot_loader_consts.vh ====
// Constants for the boot image loader
`ifndef BOOT_LOADER_CONSTS_VH
`define BOOT_LOADER_CONSTS_VH

// =====================================================
// Clock and timing
`define BOOT_CLK_NS        10
`define BOOT_STRAP_NS      100
`define BOOT_STRAP_CYC     ((`BOOT_STRAP_NS + `BOOT_CLK_NS - 1) / `BOOT_CLK_NS)
`define BOOT_HALF_DIV      4

// =====================================================
// Image format
`define BOOT_SKIP_MARKER   32'h0D15AB1E
`define BOOT_CRC_POLY      32'hEDB88320
`define BOOT_CRC_INIT      32'hFFFFFFFF
`define BOOT_NULL_CHAN     32'h0000FF02
`define BOOT_END_TOKEN     8'h01
`define BOOT_RAM_BASE      32'h00000000
`define BOOT_OTP_BASE      32'h00000000
`define BOOT_SECURE_BIT    5

// =====================================================
// Flash command bytes and sequence clock indices
`define BOOT_CMD_QUAD      8'hEB
`define BOOT_CMD_READ      8'h03
`define BOOT_CMD_CLKS      6'h08
`define BOOT_QADDR_END     6'h0E
`define BOOT_QDATA_CLK     6'h10
`define BOOT_SDATA_CLK     6'h20

// =====================================================
// Strap codes {bit2,bit1,bit0} and link enable masks
`define BOOT_STRAP_QUAD    3'h0
`define BOOT_STRAP_SPI     3'h1
`define BOOT_STRAP_SLV     3'h2
`define BOOT_STRAP_SLVALL  3'h3
`define BOOT_STRAP_LINK2   3'h4
`define BOOT_STRAP_LINK5   3'h5
`define BOOT_LINKS_2W      4'h1
`define BOOT_LINKS_5W      4'hF

`endif

// ==== hdl/boot_byte_fifo.v ====
// Synchronous FIFO between the image sources and the image parser
`timescale 1ns/1ps
module boot_byte_fifo #(
  parameter W     = 9,
  parameter DEPTH = 32,
  parameter AW    = 5
) (
  input  wire         clk,
  input  wire         srst,
  input  wire         in_valid,
  output wire         in_ready,
  input  wire [W-1:0] in_data,
  output wire         out_valid,
  input  wire         out_ready,
  output wire [W-1:0] out_data
);

  reg [W-1:0]  mem [0:DEPTH-1];
  reg [AW:0]   wr_q;
  reg [AW:0]   rd_q;
  wire [AW:0]  fill = wr_q - rd_q;

  // Honest flags from the pointer distance
  assign in_ready  = (fill != DEPTH[AW:0]);
  assign out_valid = (fill != {(AW+1){1'b0}});
  assign out_data  = mem[rd_q[AW-1:0]];

  // =====================================================
  // Pointer and storage update
  always @(posedge clk) begin
    if (srst) begin
      wr_q <= {(AW+1){1'b0}};
      rd_q <= {(AW+1){1'b0}};
    end else begin
      if (in_valid && in_ready) begin
        mem[wr_q[AW-1:0]] <= in_data;
        wr_q              <= wr_q + 1'b1;
      end
      if (out_valid && out_ready) begin
        rd_q <= rd_q + 1'b1;
      end
    end
  end

endmodule

// ==== hdl/boot_crc32_step.v ====
// One byte step of the reflected CRC-32
`timescale 1ns/1ps
`include "boot_loader_consts.vh"
module boot_crc32_step (
  input  wire [31:0] crc_in,
  input  wire [7:0]  data,
  output reg  [31:0] crc_out
);

  integer i;

  // Eight shift steps, low bit first
  always @* begin
    crc_out = crc_in ^ {24'h000000, data};
    for (i = 0; i < 8; i = i + 1) begin
      crc_out = crc_out[0] ? ((crc_out >> 1) ^ `BOOT_CRC_POLY) : (crc_out >> 1);
    end
  end

endmodule

// ==== tb/boot_loader_properties.sv ====
// Port checker for the boot image loader
`timescale 1ns/1ps
`include "boot_loader_consts.vh"
module boot_loader_properties #(parameter RAM_AW = 19) (
  input wire              core_clk,
  input wire              srst,
  input wire              strap_pulldown_en,
  input wire              flash_select_pin_out,
  input wire              serial_clock_pin_out,
  input wire [3:0]        link_tx_low_en,
  input wire [3:0]        link_pulldown_en,
  input wire              link_end_send,
  input wire [31:0]       link_end_dest,
  input wire              ram_we,
  input wire [RAM_AW-1:0] ram_addr,
  input wire              boot_exec,
  input wire [RAM_AW-1:0] exec_addr,
  input wire              boot_fail,
  input wire              crc_error
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (srst);
  reg              seen_q;
  reg [RAM_AW-1:0] last_q;
  // Remember the previous RAM write address
  always @(posedge core_clk) begin
    seen_q <= srst ? 1'h0 : (seen_q | ram_we);
    if (ram_we) last_q <= ram_addr;
  end
  property p_strap_hold; $fell(srst) |-> strap_pulldown_en [*8]; endproperty
  property p_cpol; $fell(flash_select_pin_out) |-> !serial_clock_pin_out; endproperty
  property p_exec_addr; boot_exec |-> exec_addr == '0; endproperty
  property p_exec_hold; boot_exec |=> boot_exec; endproperty
  property p_ram_step; ram_we && seen_q |-> ram_addr == last_q + 1'h1; endproperty
  property p_crc_stop; crc_error |-> boot_fail && !boot_exec; endproperty
  property p_link_pd; (link_tx_low_en & link_pulldown_en) == 4'h0; endproperty
  property p_end_send;
    link_end_send |-> link_end_dest != `BOOT_NULL_CHAN ##1 !link_end_send;
  endproperty
  a_strap_hold: assert property (p_strap_hold)
    else $error("pull-downs dropped before strap sampling");
  a_cpol: assert property (p_cpol)
    else $error("select fell with clock high");
  a_exec_addr: assert property (p_exec_addr)
    else $error("execution address not zero");
  a_exec_hold: assert property (p_exec_hold)
    else $error("execute level dropped");
  a_ram_step: assert property (p_ram_step)
    else $error("RAM address did not step by one");
  a_crc_stop: assert property (p_crc_stop)
    else $error("check failure without stop");
  a_link_pd: assert property (p_link_pd)
    else $error("pull-down on a driven link");
  a_end_send: assert property (p_end_send)
    else $error("bad end token send");
  cover property ($rose(boot_exec));
  cover property ($rose(crc_error));
  cover property (link_end_send);
endmodule
bind boot_image_loader boot_loader_properties #(.RAM_AW(RAM_AW)) chk (.core_clk(core_clk),
  .srst(srst), .strap_pulldown_en(strap_pulldown_en), .flash_select_pin_out(flash_select_pin_out),
  .serial_clock_pin_out(serial_clock_pin_out), .link_tx_low_en(link_tx_low_en),
  .link_pulldown_en(link_pulldown_en), .link_end_send(link_end_send),
  .link_end_dest(link_end_dest), .ram_we(ram_we), .ram_addr(ram_addr), .boot_exec(boot_exec),
  .exec_addr(exec_addr), .boot_fail(boot_fail), .crc_error(crc_error));

// ==== tb/spi_flash_model.sv ====
// Behavioural serial flash, single-bit and quad read
`timescale 1ns/1ps
module spi_flash_model (
  input  wire sclk,
  input  wire cs_n,
  input  wire mosi,
  output reg  miso,
  input  wire [3:0] qio_out,
  input  wire [3:0] qio_oe,
  output reg  [3:0] qio_in
);
  reg [7:0]  mem [0:255];
  reg [31:0] cmd_q;
  reg [7:0]  qcmd;
  reg [3:0]  qa;
  integer    rise_cnt = 0;
  integer    qfall = 0;
  integer    bit_idx;
  initial miso = 1'h0;
  initial qio_in = 4'h0;
  // Quad read: command on line 0, then zero address on all four lines
  // powered-up quad state, low nibble first
  always @(posedge sclk) if (!cs_n) begin
    if (qfall < 8) qcmd = {qcmd[6:0], qio_out[0]};
    else if (qfall < 14) qa = qa | qio_out | ~qio_oe;
  end
  always @(negedge sclk) if (!cs_n) begin
    qfall = qfall + 1;
    if (qfall >= 16) qio_in <= 4'(mem[(qfall - 16) / 2] >> (4 * (qfall % 2)));
  end
  // Collect command and address bits; ready at once
  // mode zero capture
  always @(posedge sclk) if (!cs_n) begin
    if (rise_cnt < 32) cmd_q = {cmd_q[30:0], mosi};
    rise_cnt = rise_cnt + 1;
  end
  // Shift image bits out after each falling edge
  // low bit first
  always @(negedge sclk) if (!cs_n && rise_cnt >= 32) begin
    bit_idx = rise_cnt - 32;
    miso <= mem[bit_idx / 8][bit_idx % 8];
  end
  // Released line shows no stale value
  always @(posedge cs_n) begin
    miso <= ~miso;
    rise_cnt = 0;
    qfall = 0;
  end
endmodule

// ==== tb/testbench.sv ====
// Self-checking bench for the boot image loader
`timescale 1ns/1ps
module testbench;
  logic        core_clk = 0, srst = 1, link_clk = 0, otp_rd_valid = 0;
  logic        slv_sck = 0, slv_mosi = 0, slv_sel_n = 1;
  logic [31:0] security_word = 0, exp_dest = 0, seed = 32'hD43B;
  logic [2:0]  strap = 0;
  logic [8:0]  link_rx_data = 0;
  logic [7:0]  otp_rd_data = 0;
  logic [7:0]  img[$];
  logic [26:0] exp_q[$];
  int          err_total, samples_checked, otp_n, ends_seen, cyc;
  wire [3:0]   qd_out, qd_oe, tx_low, pd_en, q_in;
  wire [18:0]  ram_addr, exec_addr;
  wire [31:0]  end_dest;
  wire [11:0]  otp_addr;
  wire [7:0]   ram_wdata;
  wire         strap_pd, cs_out, cs_oe, sck_out, sck_oe, mo_out, mo_oe, miso, end_send;
  wire         ce_busy, otp_req, ram_we, boot_exec, boot_fail, crc_error, ovf;
  wire         cs_w = cs_oe ? cs_out : 1'h1;
  wire         sck_w = sck_oe ? sck_out : slv_sck;
  wire         mo_w = mo_oe ? mo_out : slv_mosi;
  boot_image_loader uut (.core_clk(core_clk), .srst(srst), .security_word(security_word),
    .quad_data_in(cs_oe && !mo_oe ? q_in : {1'h0, strap}), .quad_data_out(qd_out),
    .quad_data_oe(qd_oe),
    .strap_pulldown_en(strap_pd), .flash_select_pin_out(cs_out), .flash_select_pin_oe(cs_oe),
    .serial_clock_pin_in(sck_w), .serial_clock_pin_out(sck_out), .serial_clock_pin_oe(sck_oe),
    .serial_out_or_in_pin_in(mo_w), .serial_out_or_in_pin_out(mo_out),
    .serial_out_or_in_pin_oe(mo_oe), .serial_in_or_select_pin_in(cs_oe ? miso : slv_sel_n),
    .link_clk(link_clk),
    .link_rx_data(link_rx_data), .link_tx_low_en(tx_low), .link_pulldown_en(pd_en),
    .link_end_send(end_send), .link_end_dest(end_dest), .chan_end0_busy(ce_busy),
    .otp_rd_req(otp_req), .otp_rd_addr(otp_addr), .otp_rd_data(otp_rd_data),
    .otp_rd_valid(otp_rd_valid), .ram_we(ram_we), .ram_addr(ram_addr), .ram_wdata(ram_wdata),
    .boot_exec(boot_exec), .exec_addr(exec_addr), .boot_fail(boot_fail),
    .crc_error(crc_error), .rx_overflow(ovf));
  spi_flash_model fl (.sclk(sck_w), .cs_n(cs_w), .mosi(mo_w), .miso(miso), .qio_out(qd_out),
    .qio_oe(qd_oe), .qio_in(q_in));
  // Clock and hang guard
  always #5 core_clk = ~core_clk;
  always @(posedge core_clk) begin
    cyc++;
    if (cyc == 40000) begin
      err_total++;
      print_verdict;
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("unexpected at %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  task print_verdict;
    $display("checks %0d errors %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  // Secure-memory responder, one cycle late
  always @(negedge core_clk) begin
    otp_rd_valid = 1'h0;
    if (otp_req === 1'h1) begin
      check(otp_addr, otp_n);
      otp_n++;
      otp_rd_data = img[otp_addr];
      otp_rd_valid = 1'h1;
    end
  end
  // Output watcher: RAM writes and end token sends
  always @(negedge core_clk) begin
    if (ram_we === 1'h1 && exp_q.size() == 0) check(32'h1, 32'h0);
    else if (ram_we === 1'h1) check({ram_addr, ram_wdata}, exp_q.pop_front());
    if (end_send === 1'h1) begin
      ends_seen++;
      check(end_dest, exp_dest);
    end
  end
  // Image builder with expected RAM writes
  task automatic build(input int nw, input int cm);
    logic [31:0] c, r;
    int          i, j;
    img.delete();
    exp_q.delete();
    for (i = 0; i < 4 + 4 * nw; i++) begin
      r = (i < 4) ? nw >> (8 * i) : $random(seed);
      img.push_back(r[7:0]);
      if (i > 3) exp_q.push_back({i[18:0] - 19'h4, r[7:0]});
    end
    c = 32'hFFFFFFFF;
    foreach (img[k]) for (j = 0; j < 8; j++)
      c = (c >> 1) ^ ((c[0] ^ img[k][j]) ? 32'hEDB88320 : 32'h0);
    c = (cm == 1) ? 32'h0D15AB1E : ~c ^ {31'h0, cm == 2};
    for (i = 0; i < 4; i++) img.push_back(c[8 * i +: 8]);
  endtask
  task automatic lsend(input logic [8:0] s);
    @(negedge core_clk) link_rx_data = s;
    repeat (4) @(negedge core_clk);
    link_clk = 1'h1;
    repeat (4) @(negedge core_clk);
    link_clk = 1'h0;
  endtask
  // Slave byte, low bit first; falls then rises, so idle level picks 0/0 or 1/1
  task automatic ssend(input logic [7:0] b);
    for (int j = 0; j < 8; j++) begin
      slv_sck = 1'h0;
      slv_mosi = b[j];
      repeat (4) @(negedge core_clk);
      slv_sck = 1'h1;
      repeat (4) @(negedge core_clk);
    end
  endtask
  // One boot from reset with given straps, secure flag and image
  task automatic boot(input logic [2:0] code, input logic sec, input int nw, input int cm);
    logic [31:0] r;
    int          i;
    logic        fail;
    build(nw, cm);
    foreach (img[k]) fl.mem[k] = img[k];
    r = $random(seed);
    fail = (code[2:1] == 2'h3) || cm == 2;
    @(negedge core_clk);
    srst = 1'h1;
    strap = code;
    slv_sck = code == 3'h3;
    fl.qa = 4'h0;
    otp_n = 0;
    ends_seen = 0;
    security_word = {r[31:6], sec, r[4:0]};
    repeat (16) @(negedge core_clk);
    srst = 1'h0;
    if (code[2:1] == 2'h1 && !sec) begin
      repeat (20) @(negedge core_clk);
      slv_sel_n = 1'h0;
      // external master in mode 0/0 (code 2) or 1/1 (code 3)
      foreach (img[k]) ssend(img[k]);
      slv_sel_n = 1'h1;
      slv_sck = code[0];
    end
    if (code == 3'h4) begin
      for (i = 0; tx_low !== 4'h1 && i < 200; i++) @(negedge core_clk);
      check(tx_low, 4'h1);
      check(pd_en[0], 1'h0);
      exp_dest = {r[31:1], 1'h1};
      for (i = 0; i < 4; i++) lsend({1'h0, exp_dest[8 * i +: 8]});
      foreach (img[k]) lsend({1'h0, img[k]});
      lsend({1'h1, 8'h01});
    end
    for (i = 0; boot_exec !== 1'h1 && boot_fail !== 1'h1 && i < 20000; i++)
      @(negedge core_clk);
    repeat (4) @(negedge core_clk);
    check(boot_exec, !fail);
    check(boot_fail, fail);
    check(crc_error, cm == 2);
    check(exp_q.size(), 0);
    if (code == 3'h1 && !sec) check(fl.cmd_q, 32'h03000000);
    if (code == 3'h4) check({ends_seen[3:0], ce_busy}, 5'h2);
    if (code == 3'h0) check({fl.qcmd, fl.qa, cs_oe, sck_oe}, {8'hEB, 4'h0, 2'h3});
    check({ovf, strap_pd}, 2'h0);
  endtask
  // Main sequence: flash, link, secure override with bad sum, reserved code
  initial begin
    boot(3'h1, 1'h0, 4, 0);
    boot(3'h0, 1'h0, 4, 0);
    boot(3'h2, 1'h0, 1, 1);
    boot(3'h3, 1'h0, 2, 0);
    boot(3'h4, 1'h0, 3, 1);
    boot(3'h1, 1'h1, 2, 2);
    boot(3'h6, 1'h0, 0, 0);
    print_verdict;
  end
endmodule
